// >>> hw/cot_oc_chk.sv
`include "cot_params.svh"

module cot_oc_chk (
    // clock and reset
    input  wire logic              CORE_CLK,
    input  wire logic              RSTN,
    // sensed current, 62.5 mA units
    input  wire logic signed [11:0] RAW,
    // effective settings
    input  wire logic signed [10:0] OFS_MANT,
    input  wire logic        [10:0] LIM_MANT,
    input  wire logic signed [10:0] WARN_MANT,
    // results
    output logic signed [12:0]      CORR,
    output logic                    FLT,
    output logic                    WRN
);
    import cot_pkg::*;

    cot_chk_st_t st_reg;
    cot_chk_st_t st_next;
    logic signed [12:0] corr_w;
    logic signed [14:0] lim_w;
    logic signed [14:0] warn_w;

    always_comb begin
        // R4 offset corrects reading
        corr_w = 13'(RAW) + 13'(OFS_MANT);
        // R18 scale limits to 62.5 mA units
        lim_w  = 15'($signed({1'b0, LIM_MANT})) <<< `COT_OCL_SHIFT;
        warn_w = 15'(WARN_MANT) <<< `COT_OCL_SHIFT;
        st_next.corr = corr_w;
        // R12 fault on reaching threshold
        st_next.flt = 15'(corr_w) >= lim_w;
        st_next.wrn = 15'(corr_w) >= warn_w;
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign CORR = st_reg.corr;
    assign FLT  = st_reg.flt;
    assign WRN  = st_reg.wrn;
endmodule // cot_oc_chk

// >>> hw/cot_params.svh
// Notes on behaviour
// R1 - offset trim: signed, 62.5 mA step, zero default
// R2 - no range check; fixed bits alias values
// R3 - exponent -4; five mantissa msbs copy sign
// R4 - offset applied to reading and both limits; code offsets the reading only, limits are compared unoffset
// R5 - page bits 7,0 select channel or both
// R6 - channel 1 always writable; channel 2 when master
// R7 - slave channel 2 uses channel 1 setting
// R8 - slave channel 2 write: nack, invalid command, alert
// R9 - host matches stacked slave to master value
// R10 - read-only bits ignore writes, keep contents
// R11 - offset exponent reads 11100, mantissa default zero
// R12 - overcurrent fault when current reaches threshold
// R13 - threshold below warning: cml, invalid data, alert
// R14 - host keeps fault threshold at or above warning
// R15 - threshold exponent fixed 11111, mantissa writable
// R16 - threshold resets to F850, forty amps
// R17 - power-up defaults from stored user values
// R18 - value is mantissa times two to exponent
`ifndef COT_PARAMS_SVH
`define COT_PARAMS_SVH

// command codes
`define COT_CMD_PAGE      8'h00
`define COT_CMD_CLEAR     8'h03
`define COT_CMD_OFFSET    8'h39
`define COT_CMD_OCLIM     8'h46
`define COT_CMD_STATUS    8'h78
`define COT_CMD_CML       8'h7E

// word layout
`define COT_EXP_HI        15
`define COT_EXP_LO        11
`define COT_SIGN_BIT      10
`define COT_OFS_EXT_HI    9
`define COT_OFS_EXT_LO    6
`define COT_OFS_FREE_HI   5
`define COT_OCL_FREE_HI   6

// fixed fields and reset values
`define COT_OFS_EXP       5'h1C
`define COT_OCL_EXP       5'h1F
`define COT_OFS_RST       16'hE000
`define COT_OCL_RST       16'hF850
`define COT_PAGE_RST      8'h00

// page field bits
`define COT_PAGE_HI_BIT   7
`define COT_PAGE_LO_BIT   0

// status bit positions
`define COT_STAT_CML_BIT  1
`define COT_CML_IVC_BIT   7
`define COT_CML_IVD_BIT   6

// 0.5 A step over 62.5 mA step is 2^3
`define COT_OCL_SHIFT     3

`endif

// >>> hw/cot_pkg.sv
package cot_pkg;

    typedef logic [1:0][11:0] cot_raw_t;
    typedef logic [1:0][12:0] cot_corr_t;
    typedef logic [1:0][15:0] cot_words_t;
    typedef logic [1:0][10:0] cot_mant_t;

    typedef struct packed {
        logic [7:0]  page;
        cot_words_t  ofs;
        cot_words_t  lim;
        logic        loaded;
        logic        done;
        logic        nack;
        logic [15:0] rdata;
        logic        cml;
        logic        ivd;
        logic        invalid_command_fault;
    } cot_top_st_t;

    typedef struct packed {
        logic signed [12:0] corr;
        logic               flt;
        logic               wrn;
    } cot_chk_st_t;

    typedef struct packed {
        logic meta;
        logic sync;
    } cot_sync_st_t;

endpackage

// >>> hw/cot_regs.sv
`include "cot_params.svh"

module cot_regs (
    // clock and reset
    input  wire logic               CORE_CLK,
    input  wire logic               RSTN,
    // command port from the bus engine
    input  wire logic               CMD_STB,
    input  wire logic               CMD_WR,
    input  wire logic [7:0]         CMD_CODE,
    input  wire logic [15:0]        CMD_WDATA,
    output logic                    RSP_DONE,
    output logic                    RSP_NACK,
    output logic [15:0]             RSP_RDATA,
    // alert, active low
    output logic                    SMB_ALERT_N,
    // channel 2 slave strap pin
    input  wire logic               CH2_SLAVE,
    // stored user defaults
    input  wire logic               NVM_VALID,
    input  wire cot_pkg::cot_words_t NVM_OFS,
    input  wire cot_pkg::cot_words_t NVM_LIM,
    // warning thresholds, 0.5 A mantissas
    input  wire cot_pkg::cot_mant_t WARN_MANT,
    // sensed currents and results
    input  wire cot_pkg::cot_raw_t  IOUT_RAW,
    output cot_pkg::cot_corr_t      IOUT_CORR,
    output logic [1:0]              OC_FAULT,
    output logic [1:0]              OC_WARN
);
    import cot_pkg::*;

    cot_top_st_t st_reg;
    cot_top_st_t st_next;
    logic        slave_s;
    cot_words_t  ofs_eff;
    cot_words_t  lim_eff;

    // R3 force exponent and sign extension
    function automatic logic [15:0] fix_ofs(input logic [15:0] w);
        logic s;
        s = w[`COT_SIGN_BIT];
        // R10 read-only bits never taken
        fix_ofs = {`COT_OFS_EXP, s, {4{s}}, w[`COT_OFS_FREE_HI:0]};
    endfunction

    // R15 only low mantissa bits writable
    function automatic logic [15:0] fix_lim(input logic [15:0] w);
        fix_lim = {`COT_OCL_EXP, 4'h0, w[`COT_OCL_FREE_HI:0]};
    endfunction

    // R5 page to channel select, bit2 flags bad code
    function automatic logic [2:0] page_sel(input logic [7:0] p);
        logic [1:0] k;
        k = {p[`COT_PAGE_HI_BIT], p[`COT_PAGE_LO_BIT]};
        if (k == 2'h0) begin
            page_sel = 3'h1;
        end else if (k == 2'h1) begin
            page_sel = 3'h2;
        end else if (k == 2'h3) begin
            page_sel = 3'h3;
        end else begin
            page_sel = 3'h4;
        end
    endfunction

    // strap is a pin: two flops first
    cot_sync u_slave_sync (
        .CORE_CLK (CORE_CLK),
        .RSTN     (RSTN),
        .D        (CH2_SLAVE),
        .Q        (slave_s)
    );

    always_comb begin
        // R7 slave channel 2 follows channel 1
        ofs_eff[0] = st_reg.ofs[0];
        lim_eff[0] = st_reg.lim[0];
        ofs_eff[1] = slave_s ? st_reg.ofs[0] : st_reg.ofs[1];
        lim_eff[1] = slave_s ? st_reg.lim[0] : st_reg.lim[1];
    end

    always_comb begin
        logic [2:0]  sel;
        logic        rd_ch;
        logic [15:0] lim_new;
        sel     = page_sel(st_reg.page);
        rd_ch   = 1'b0;
        lim_new = fix_lim(CMD_WDATA);
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.nack = 1'b0;
        if (!st_reg.loaded) begin
            st_next.loaded = 1'b1;
            // R17 stored user values replace defaults
            if (NVM_VALID) begin
                for (int i = 0; i < 2; i++) begin
                    st_next.ofs[i] = fix_ofs(NVM_OFS[i]);
                    st_next.lim[i] = fix_lim(NVM_LIM[i]);
                end
            end
        end else if (CMD_STB) begin
            st_next.done = 1'b1;
            if (CMD_WR) begin
                if (CMD_CODE == `COT_CMD_PAGE) begin
                    st_next.page = CMD_WDATA[7:0];
                end else if (CMD_CODE == `COT_CMD_CLEAR) begin
                    st_next.cml = 1'b0;
                    st_next.ivd = 1'b0;
                    st_next.invalid_command_fault = 1'b0;
                end else if (CMD_CODE == `COT_CMD_OFFSET || CMD_CODE == `COT_CMD_OCLIM) begin
                    if (sel[2]) begin
                        st_next.nack = 1'b1;
                        st_next.invalid_command_fault  = 1'b1;
                    end else begin
                        // R6 channel 1 always taken
                        if (sel[0]) begin
                            if (CMD_CODE == `COT_CMD_OFFSET) begin
                                // R2 no range check, alias only
                                st_next.ofs[0] = fix_ofs(CMD_WDATA);
                            end else begin
                                st_next.lim[0] = lim_new;
                            end
                        end
                        // R8 slave write refused
                        if (sel[1] && slave_s) begin
                            st_next.nack = 1'b1;
                            st_next.invalid_command_fault  = 1'b1;
                        end else if (sel[1]) begin
                            if (CMD_CODE == `COT_CMD_OFFSET) begin
                                st_next.ofs[1] = fix_ofs(CMD_WDATA);
                            end else begin
                                st_next.lim[1] = lim_new;
                            end
                        end
                        // R13 threshold below warning
                        if (CMD_CODE == `COT_CMD_OCLIM) begin
                            for (int i = 0; i < 2; i++) begin
                                if (sel[i] && !(i == 1 && slave_s) &&
                                    $signed({1'b0, lim_new[10:0]}) < $signed({WARN_MANT[i][10], WARN_MANT[i]})) begin
                                    st_next.ivd = 1'b1;
                                end
                            end
                        end
                    end
                end else begin
                    st_next.nack = 1'b1;
                    st_next.invalid_command_fault  = 1'b1;
                end
            end else begin
                rd_ch = (sel == 3'h2);
                if (CMD_CODE == `COT_CMD_PAGE) begin
                    st_next.rdata = {8'h00, st_reg.page};
                end else if (CMD_CODE == `COT_CMD_OFFSET) begin
                    // R11 exponent field read back fixed
                    st_next.rdata = ofs_eff[rd_ch];
                end else if (CMD_CODE == `COT_CMD_OCLIM) begin
                    st_next.rdata = lim_eff[rd_ch];
                end else if (CMD_CODE == `COT_CMD_STATUS) begin
                    st_next.rdata = '0;
                    st_next.rdata[`COT_STAT_CML_BIT] = st_reg.cml;
                end else if (CMD_CODE == `COT_CMD_CML) begin
                    st_next.rdata = '0;
                    st_next.rdata[`COT_CML_IVC_BIT] = st_reg.invalid_command_fault;
                    st_next.rdata[`COT_CML_IVD_BIT] = st_reg.ivd;
                end else begin
                    st_next.rdata = '0;
                    st_next.nack  = 1'b1;
                    st_next.invalid_command_fault   = 1'b1;
                end
            end
            // R13 any comm fault raises cml
            if (st_next.invalid_command_fault || st_next.ivd) begin
                st_next.cml = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            // R16 threshold reset; R1 offset zero
            st_reg <= '{page:   `COT_PAGE_RST,
                        ofs:    {`COT_OFS_RST, `COT_OFS_RST},
                        lim:    {`COT_OCL_RST, `COT_OCL_RST},
                        loaded: 1'b0,
                        done:   1'b0,
                        nack:   1'b0,
                        rdata:  16'h0000,
                        cml:    1'b0,
                        ivd:    1'b0,
                        invalid_command_fault:    1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // one checker per channel
    generate
        for (genvar g = 0; g < 2; g++) begin : g_chk
            cot_oc_chk u_chk (
                .CORE_CLK  (CORE_CLK),
                .RSTN      (RSTN),
                .RAW       (IOUT_RAW[g]),
                .OFS_MANT  (ofs_eff[g][10:0]),
                .LIM_MANT  (lim_eff[g][10:0]),
                .WARN_MANT (WARN_MANT[g]),
                .CORR      (IOUT_CORR[g]),
                .FLT       (OC_FAULT[g]),
                .WRN       (OC_WARN[g])
            );
        end
    endgenerate

    assign RSP_DONE    = st_reg.done;
    assign RSP_NACK    = st_reg.nack;
    assign RSP_RDATA   = st_reg.rdata;
    // R8 alert follows latched faults
    assign SMB_ALERT_N = !(st_reg.cml || st_reg.ivd || st_reg.invalid_command_fault);
endmodule // cot_regs

// >>> hw/cot_sync.sv
module cot_sync (
    // clock and reset
    input  wire logic CORE_CLK,
    input  wire logic RSTN,
    // level in and out
    input  wire logic D,
    output logic      Q
);
    import cot_pkg::*;

    cot_sync_st_t st_reg;
    cot_sync_st_t st_next;

    always_comb begin
        st_next.meta = D;
        st_next.sync = st_reg.meta;
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign Q = st_reg.sync;
endmodule // cot_sync

// >>> test/cot_host.sv
module cot_host (
    // clock
    input  wire logic        CORE_CLK,
    // request
    output logic             CMD_STB,
    output logic             CMD_WR,
    output logic [7:0]       CMD_CODE,
    output logic [15:0]      CMD_WDATA,
    // answer
    input  wire logic        RSP_DONE,
    input  wire logic        RSP_NACK,
    input  wire logic [15:0] RSP_RDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        CMD_STB = 1'b0;
        CMD_WR = 1'b0;
        CMD_CODE = 8'h00;
        CMD_WDATA = 16'h0000;
    end
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] r, output logic [1:0] s);
        @(negedge CORE_CLK);
        CMD_STB = 1'b1;
        CMD_WR = w;
        CMD_CODE = c;
        CMD_WDATA = d;
        @(negedge CORE_CLK);
        r = RSP_RDATA;
        s = {RSP_DONE, RSP_NACK};
        CMD_STB = 1'b0;
        // released data must not echo the old word
        CMD_WDATA = ~d;
    endtask
endmodule // cot_host

// >>> test/cot_regs_chk.sv
module cot_regs_chk (
    // clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RSTN,
    // command port
    input wire logic        CMD_STB,
    input wire logic        CMD_WR,
    input wire logic [7:0]  CMD_CODE,
    input wire logic        RSP_DONE,
    input wire logic        RSP_NACK,
    input wire logic [15:0] RSP_RDATA,
    input wire logic        SMB_ALERT_N
);
    timeunit 1ns;
    timeprecision 1ns;
    logic live_reg;
    logic clr;
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);
    // first edge after reset is the load cycle
    always_ff @(posedge CORE_CLK or negedge RSTN)
        if (!RSTN) live_reg <= 1'b0;
        else live_reg <= 1'b1;
    assign clr = CMD_STB && CMD_WR && (CMD_CODE == 8'h03) && live_reg;
    sequence s_take;
        CMD_STB && live_reg;
    endsequence
    sequence s_cleared;
        ##[1:2] SMB_ALERT_N;
    endsequence
    AST_ANSWER: assert property (s_take |=> RSP_DONE)
        else $error("command not answered");
    AST_NO_STRAY: assert property (RSP_DONE |-> $past(CMD_STB))
        else $error("answer without command");
    AST_NACK_DONE: assert property (RSP_NACK |-> RSP_DONE)
        else $error("refusal outside answer");
    AST_NACK_ALERT: assert property (RSP_NACK |-> !SMB_ALERT_N)
        else $error("refusal without alert");
    AST_CLEAR: assert property (clr |-> s_cleared)
        else $error("alert kept after clear");
    AST_FALL: assert property ($fell(SMB_ALERT_N) |-> $past(CMD_STB) || $past(CMD_STB, 2))
        else $error("alert without command");
    AST_RISE: assert property ($rose(SMB_ALERT_N) |-> $past(clr) || $past(clr, 2))
        else $error("alert released without clear");
    AST_RDATA: assert property ($changed(RSP_RDATA) |-> RSP_DONE && !$past(CMD_WR))
        else $error("read data moved without read");
endmodule // cot_regs_chk

bind cot_regs cot_regs_chk i_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CMD_STB(CMD_STB), .CMD_WR(CMD_WR),
    .CMD_CODE(CMD_CODE), .RSP_DONE(RSP_DONE), .RSP_NACK(RSP_NACK), .RSP_RDATA(RSP_RDATA),
    .SMB_ALERT_N(SMB_ALERT_N));

// >>> test/cot_regs_tb.sv
module cot_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cot_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        slv = 1'b0;
    logic        nvm_ok = 1'b0;
    logic        stb, wr_en, done, nack, alert_n;
    logic [7:0]  code;
    logic [15:0] wdata, rdata;
    logic [1:0]  flt, wrn;
    cot_words_t  nvm_ofs = '0;
    cot_words_t  nvm_lim = '0;
    cot_mant_t   warn = '0;
    cot_raw_t    raw = '0;
    cot_corr_t   corr;
    logic [15:0] mo [2];
    logic [15:0] ml [2];
    logic [7:0]  mp;
    logic [7:0]  pg [3] = '{8'h00, 8'h01, 8'h81};
    int          checks = 0;
    int          failures = 0;
    int          cyc = 0;

    cot_host i_host (.CORE_CLK(clk), .CMD_STB(stb), .CMD_WR(wr_en), .CMD_CODE(code), .CMD_WDATA(wdata),
        .RSP_DONE(done), .RSP_NACK(nack), .RSP_RDATA(rdata));
    cot_regs i_cot_regs (.CORE_CLK(clk), .RSTN(rstn), .CMD_STB(stb), .CMD_WR(wr_en), .CMD_CODE(code),
        .CMD_WDATA(wdata), .RSP_DONE(done), .RSP_NACK(nack), .RSP_RDATA(rdata), .SMB_ALERT_N(alert_n),
        .CH2_SLAVE(slv), .NVM_VALID(nvm_ok), .NVM_OFS(nvm_ofs), .NVM_LIM(nvm_lim), .WARN_MANT(warn),
        .IOUT_RAW(raw), .IOUT_CORR(corr), .OC_FAULT(flt), .OC_WARN(wrn));

    always #25 clk = ~clk;

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            failures = failures + 1;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    function automatic logic [15:0] fo(input logic [15:0] w);
        return {5'h1C, {5{w[10]}}, w[5:0]};
    endfunction
    function automatic logic [15:0] fl(input logic [15:0] w);
        return {5'h1F, 4'h0, w[6:0]};
    endfunction
    function automatic logic [15:0] mv(input logic [7:0] c);
        logic ch;
        ch = mp[0] && !mp[7] && !slv;
        return (c == 8'h39) ? mo[ch] : ml[ch];
    endfunction

    task automatic reset();
        rstn = 1'b0;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        mp = 8'h00;
        for (int k = 0; k < 2; k++) begin
            mo[k] = nvm_ok ? fo(nvm_ofs[k]) : 16'hE000;
            ml[k] = nvm_ok ? fl(nvm_lim[k]) : 16'hF850;
        end
        repeat (2) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        logic [15:0] r;
        logic [1:0]  s;
        logic        nk;
        // slave ch2, page code 10 or unknown code refused
        nk = ((c == 8'h39) || (c == 8'h46)) && ((mp[0] && slv) || (mp[7] && !mp[0]));
        nk = nk || !((c == 8'h00) || (c == 8'h03) || (c == 8'h39) || (c == 8'h46));
        if (c == 8'h00) mp = d[7:0];
        for (int k = 0; k < 2; k++)
            if (k ? (mp[0] && !slv) : (mp[0] == mp[7])) begin
                if (c == 8'h39) mo[k] = fo(d);
                if (c == 8'h46) ml[k] = fl(d);
            end
        i_host.xfer(1'b1, c, d, r, s);
        check("ack", {14'h0, s}, {14'h0, 1'b1, nk});
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] r;
        logic [1:0]  s;
        logic        nk;
        nk = !((c == 8'h00) || (c == 8'h39) || (c == 8'h46) || (c == 8'h78) || (c == 8'h7E));
        i_host.xfer(1'b0, c, 16'h0000, r, s);
        check("rdata", r, e);
        check("rnak", {14'h0, s}, {14'h0, 1'b1, nk});
    endtask

    task automatic rdall();
        for (int p = 0; p < 2; p++) begin
            wr(8'h00, 16'(p));
            rd(8'h39, mv(8'h39));
            rd(8'h46, mv(8'h46));
        end
    endtask

    task automatic iout();
        int c;
        int e;
        raw = 24'($urandom);
        repeat (2) @(negedge clk);
        for (int k = 0; k < 2; k++) begin
            e = slv ? 0 : k;
            c = $signed(raw[k]) + $signed(mo[e][10:0]);
            check("corr", {3'h0, corr[k]}, {3'h0, 13'(c)});
            check("flt", 16'(flt[k]), 16'(c >= 8 * int'(ml[e][6:0])));
            check("wrn", 16'(wrn[k]), 16'(c >= 0));
        end
    endtask

    initial begin
        void'($urandom(32'h82e9d633));
        reset();
        rdall();
        for (int i = 0; i < 12; i++) begin
            wr(8'h00, {8'h00, pg[i % 3]});
            wr(8'h39, 16'($urandom));
            wr(8'h46, 16'($urandom));
            rdall();
            iout();
        end
        warn[0] = 11'd20;
        wr(8'h00, 16'h0000);
        wr(8'h46, 16'h0005);
        check("alert", 16'(alert_n), 16'h0000);
        rd(8'h78, 16'h0002);
        rd(8'h7E, 16'h0040);
        wr(8'h03, 16'h0000);
        check("alert", 16'(alert_n), 16'h0001);
        warn[0] = 11'd0;
        // unknown code and page code 10 are refused
        rd(8'h55, 16'h0000);
        wr(8'h00, 16'h0080);
        wr(8'h39, 16'h0123);
        rd(8'h7E, 16'h0080);
        rd(8'h39, mv(8'h39));
        wr(8'h03, 16'h0000);
        slv = 1'b1;
        repeat (4) @(negedge clk);
        wr(8'h00, 16'h0001);
        wr(8'h39, 16'h0421);
        rd(8'h7E, 16'h0080);
        rd(8'h39, mv(8'h39));
        // host sets ch1, which the slave shares
        wr(8'h00, 16'h0081);
        wr(8'h46, 16'h0033);
        rdall();
        iout();
        wr(8'h03, 16'h0000);
        slv = 1'b0;
        nvm_ok = 1'b1;
        nvm_ofs = 32'($urandom);
        nvm_lim = 32'($urandom);
        reset();
        rdall();
        finish_test();
    end
endmodule // cot_regs_tb
